// File: rtl/ccd_pkg.sv
// Constants and types for the CPU core clock and datapath block
package ccd_pkg;
   // Register byte offsets
   localparam logic [11:0] CCD_OFF_CLKSEL = 12'h000;
   localparam logic [11:0] CCD_OFF_CMD = 12'h004;
   localparam logic [11:0] CCD_OFF_ACC = 12'h008;
   localparam logic [11:0] CCD_OFF_BREG = 12'h00c;
   localparam logic [11:0] CCD_OFF_EREG = 12'h010;
   localparam logic [11:0] CCD_OFF_DREG = 12'h014;
   localparam logic [11:0] CCD_OFF_STACK = 12'h018;
   localparam logic [11:0] CCD_OFF_PC = 12'h01c;
   localparam logic [11:0] CCD_OFF_STATUS = 12'h020;
   localparam logic [11:0] CCD_OFF_MEM = 12'h024;
   localparam logic [11:0] CCD_OFF_DPTR = 12'h028;
   // Clock select fields
   localparam int CCD_SEL_SUB = 0;
   localparam int CCD_SEL_STOP = 1;
   localparam int CCD_DIV_LO = 2;
   localparam logic [3:0] CCD_CLKSEL_RST = 4'hc;
   localparam logic [1:0] CCD_INSTR_DIV = 2'h2;
   localparam logic [2:0] CCD_SP_RST = 3'h7;
   localparam logic [1:0] CCD_MAIN_RING = 2'h0;
   localparam logic [1:0] CCD_MAIN_CER = 2'h1;
   localparam logic [1:0] CCD_MAIN_RC = 2'h2;
   // Command codes written to the command register
   typedef enum logic [4:0] {
      CCD_OP_NOP = 5'h00,
      CCD_OP_ADD_IMM = 5'h01,
      CCD_OP_ADD_MEM = 5'h02,
      CCD_OP_ADC_MEM = 5'h03,
      CCD_OP_AND_MEM = 5'h04,
      CCD_OP_OR_MEM = 5'h05,
      CCD_OP_CMP_MEM = 5'h06,
      CCD_OP_SETBIT = 5'h07,
      CCD_OP_CLRBIT = 5'h08,
      CCD_OP_ROR_C = 5'h09,
      CCD_OP_SET_C = 5'h0a,
      CCD_OP_CLR_C = 5'h0b,
      CCD_OP_BA_TO_E = 5'h0c,
      CCD_OP_E_TO_BA = 5'h0d,
      CCD_OP_CALL = 5'h0e,
      CCD_OP_RET = 5'h0f,
      CCD_OP_TABLE = 5'h10,
      CCD_OP_IJMP = 5'h11,
      CCD_OP_ICALL = 5'h12,
      CCD_OP_SP_TO_A = 5'h13,
      CCD_OP_INT = 5'h14,
      CCD_OP_RETI = 5'h15,
      CCD_OP_CERAMIC = 5'h16,
      CCD_OP_RCOSC = 5'h17,
      CCD_OP_A_TO_B = 5'h18,
      CCD_OP_B_TO_A = 5'h19
   } ccd_op_t;
endpackage

// File: rtl/ccd_core.sv
// CPU core: clock selector, divider and 4-bit datapath with APB access
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
module ccd_core #(
   parameter int PC_W = 14,
   parameter int DP_W = 9,
   parameter int STACK_DEPTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic main_osc_clk,
   input wire logic ring_osc_clk,
   input wire logic sub_osc_clk,
   input wire logic skip_flag_in,
   output logic main_osc_enable,
   output logic system_clock,
   output logic instruction_clock,
   output logic machine_cycle,
   output logic [6:0] inpage_rom_addr
);
   import ccd_pkg::*;

   localparam int SP_W = $clog2(STACK_DEPTH);
   localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);

   logic [3:0] clksel_reg, clksel_next;
   logic [1:0] mainsrc_reg, mainsrc_next;
   logic [3:0] acc_reg, acc_next;
   logic carry_reg, carry_next;
   logic [3:0] b_reg, b_next;
   logic [7:0] e_reg, e_next;
   logic [2:0] d_reg, d_next;
   logic [3:0] mem_reg, mem_next;
   logic [3:0] imm_reg, imm_next;
   logic [DP_W-1:0] dptr_reg, dptr_next;
   logic [PC_W-1:0] pc_reg, pc_next;
   logic [PC_W-1:0] target_reg, target_next;
   logic [SP_W-1:0] sp_reg, sp_next;
   logic [PC_W-1:0] stack_mem [STACK_DEPTH];
   logic [PC_W-1:0] stack_wdata;
   logic stack_we;
   logic cmp_eq_reg, cmp_eq_next;
   logic skip_reg, skip_next;
   logic [DP_W-1:0] ctx_dp_reg, ctx_dp_next;
   logic ctx_c_reg, ctx_c_next;
   logic ctx_s_reg, ctx_s_next;
   logic [3:0] ctx_a_reg, ctx_a_next;
   logic [3:0] ctx_b_reg, ctx_b_next;
   logic [3:0] div_reg, div_next;
   logic [1:0] inst_reg, inst_next;
   logic sys_reg, sys_next;
   logic src_tick;
   logic sys_tick;
   logic wr_en, rd_en;
   logic [31:0] rdata_next;
   logic err_next;
   logic [4:0] cmd;
   logic [4:0] add_sum;
   logic [3:0] div_mask;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode: zero wait states, unmapped reads give zero and an error
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign cmd = pwdata[4:0];

   always_comb begin
      rdata_next = 32'h0000_0000;
      err_next = 1'b0;
      unique case (paddr)
         CCD_OFF_CLKSEL: rdata_next[3:0] = clksel_reg;
         CCD_OFF_CMD: rdata_next[1:0] = mainsrc_reg;
         CCD_OFF_ACC: rdata_next[4:0] = {carry_reg, acc_reg};
         CCD_OFF_BREG: rdata_next[3:0] = b_reg;
         CCD_OFF_EREG: rdata_next[7:0] = e_reg;
         CCD_OFF_DREG: rdata_next[2:0] = d_reg;
         CCD_OFF_STACK: rdata_next[SP_W-1:0] = sp_reg;
         CCD_OFF_PC: rdata_next[PC_W-1:0] = pc_reg;
         CCD_OFF_STATUS: rdata_next[1:0] = {skip_reg, cmp_eq_reg};
         CCD_OFF_MEM: rdata_next[3:0] = mem_reg;
         CCD_OFF_DPTR: rdata_next[DP_W-1:0] = dptr_reg;
         default: err_next = psel;
      endcase
   end

   // Read data is combinational off registered state within the access cycle
   assign prdata = rd_en ? rdata_next : 32'h0000_0000;
   assign pslverr = psel & penable & err_next;

   ////////////////////////////////////////////////////////////////////////
   // Clock source selection and division, counted in pclk ticks
   always_comb begin
      unique case (mainsrc_reg)
         CCD_MAIN_CER, CCD_MAIN_RC: src_tick = main_osc_clk;
         default: src_tick = ring_osc_clk;
      endcase
      if (clksel_reg[CCD_SEL_SUB]) begin
         src_tick = sub_osc_clk;
      end
      // Divide by 1, 2, 4 or 8 from the two upper select bits
      div_mask = 4'((4'h1 << clksel_reg[3:CCD_DIV_LO]) - 4'h1);
      div_next = div_reg;
      sys_tick = 1'b0;
      if (src_tick) begin
         if ((div_reg & div_mask) == div_mask) begin
            div_next = 4'h0;
            sys_tick = 1'b1;
         end else begin
            div_next = 4'(div_reg + 4'h1);
         end
      end
      sys_next = sys_reg ^ sys_tick;
      // Instruction clock: one pulse every third system tick
      inst_next = inst_reg;
      if (sys_tick) begin
         inst_next = (inst_reg == CCD_INSTR_DIV) ? 2'h0 :
            2'(inst_reg + 2'h1);
      end
   end

   // Main oscillator held off while sub-clock runs with the stop bit set
   assign main_osc_enable = ~(clksel_reg[CCD_SEL_SUB] &
      clksel_reg[CCD_SEL_STOP]);
   assign system_clock = sys_reg;
   assign instruction_clock = (inst_reg == 2'h0);
   // One machine cycle per instruction clock period
   assign machine_cycle = sys_tick & (inst_reg == CCD_INSTR_DIV);
   assign inpage_rom_addr = {d_reg, acc_reg};

   ////////////////////////////////////////////////////////////////////////
   // Datapath: commands execute in the pclk cycle of their command register write
   always_comb begin
      clksel_next = clksel_reg;
      mainsrc_next = mainsrc_reg;
      acc_next = acc_reg;
      carry_next = carry_reg;
      b_next = b_reg;
      e_next = e_reg;
      d_next = d_reg;
      mem_next = mem_reg;
      imm_next = imm_reg;
      dptr_next = dptr_reg;
      pc_next = pc_reg;
      target_next = target_reg;
      sp_next = sp_reg;
      stack_we = 1'b0;
      stack_wdata = pc_reg;
      cmp_eq_next = cmp_eq_reg;
      skip_next = skip_reg;
      ctx_dp_next = ctx_dp_reg;
      ctx_c_next = ctx_c_reg;
      ctx_s_next = ctx_s_reg;
      ctx_a_next = ctx_a_reg;
      ctx_b_next = ctx_b_reg;
      add_sum = {1'b0, acc_reg} + {1'b0, mem_reg};
      if (wr_en) begin
         unique case (paddr)
            CCD_OFF_CLKSEL: clksel_next = pwdata[3:0];
            CCD_OFF_ACC: acc_next = pwdata[3:0];
            CCD_OFF_BREG: b_next = pwdata[3:0];
            CCD_OFF_EREG: e_next = pwdata[7:0];
            CCD_OFF_DREG: d_next = pwdata[2:0];
            CCD_OFF_PC: target_next = pwdata[PC_W-1:0];
            CCD_OFF_MEM: mem_next = pwdata[3:0];
            CCD_OFF_DPTR: dptr_next = pwdata[DP_W-1:0];
            CCD_OFF_STATUS: imm_next = pwdata[11:8];
            CCD_OFF_CMD: begin
               unique case (cmd)
                  CCD_OP_ADD_IMM: acc_next = 4'(acc_reg + imm_reg);
                  CCD_OP_ADD_MEM: acc_next = add_sum[3:0];
                  CCD_OP_ADC_MEM: begin
                     add_sum = 5'({1'b0, acc_reg} + {1'b0, mem_reg} +
                        {4'h0, carry_reg});
                     acc_next = add_sum[3:0];
                     carry_next = add_sum[4];
                  end
                  CCD_OP_AND_MEM: acc_next = acc_reg & mem_reg;
                  CCD_OP_OR_MEM: acc_next = acc_reg | mem_reg;
                  CCD_OP_CMP_MEM: cmp_eq_next = (acc_reg == mem_reg);
                  CCD_OP_SETBIT: mem_next = mem_reg | (4'h1 << imm_reg[1:0]);
                  CCD_OP_CLRBIT: mem_next = mem_reg & ~(4'h1 << imm_reg[1:0]);
                  CCD_OP_ROR_C: begin
                     acc_next = {carry_reg, acc_reg[3:1]};
                     carry_next = acc_reg[0];
                  end
                  CCD_OP_SET_C: carry_next = 1'b1;
                  CCD_OP_CLR_C: carry_next = 1'b0;
                  CCD_OP_BA_TO_E: e_next = {b_reg, acc_reg};
                  CCD_OP_E_TO_BA: begin
                     b_next = e_reg[7:4];
                     acc_next = e_reg[3:0];
                  end
                  CCD_OP_A_TO_B: b_next = acc_reg;
                  CCD_OP_B_TO_A: acc_next = b_reg;
                  CCD_OP_CALL, CCD_OP_TABLE, CCD_OP_ICALL: begin
                     // Wraps so the ninth level lands on entry 0 again
                     sp_next = sp_reg + SP_ONE;
                     stack_we = 1'b1;
                     pc_next = (cmd == CCD_OP_CALL) ? target_reg :
                        {pc_reg[PC_W-1:7], d_reg, acc_reg};
                  end
                  CCD_OP_INT: begin
                     sp_next = sp_reg + SP_ONE;
                     stack_we = 1'b1;
                     pc_next = target_reg;
                     ctx_dp_next = dptr_reg;
                     ctx_c_next = carry_reg;
                     ctx_s_next = skip_flag_in;
                     ctx_a_next = acc_reg;
                     ctx_b_next = b_reg;
                  end
                  CCD_OP_RET: begin
                     pc_next = stack_mem[sp_reg];
                     sp_next = sp_reg - SP_ONE;
                  end
                  CCD_OP_RETI: begin
                     pc_next = stack_mem[sp_reg];
                     sp_next = sp_reg - SP_ONE;
                     dptr_next = ctx_dp_reg;
                     carry_next = ctx_c_reg;
                     skip_next = ctx_s_reg;
                     acc_next = ctx_a_reg;
                     b_next = ctx_b_reg;
                  end
                  CCD_OP_IJMP: pc_next = {pc_reg[PC_W-1:7], d_reg, acc_reg};
                  CCD_OP_SP_TO_A: acc_next = 4'(sp_reg);
                  CCD_OP_CERAMIC: mainsrc_next = CCD_MAIN_CER;
                  CCD_OP_RCOSC: mainsrc_next = CCD_MAIN_RC;
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State registers; E, D and the stack body carry no reset value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clksel_reg <= CCD_CLKSEL_RST;
         mainsrc_reg <= CCD_MAIN_RING;
         acc_reg <= 4'h0;
         carry_reg <= 1'b0;
         b_reg <= 4'h0;
         mem_reg <= 4'h0;
         imm_reg <= 4'h0;
         dptr_reg <= '0;
         pc_reg <= '0;
         target_reg <= '0;
         sp_reg <= SP_W'(CCD_SP_RST);
         cmp_eq_reg <= 1'b0;
         skip_reg <= 1'b0;
         ctx_dp_reg <= '0;
         ctx_c_reg <= 1'b0;
         ctx_s_reg <= 1'b0;
         ctx_a_reg <= 4'h0;
         ctx_b_reg <= 4'h0;
         div_reg <= 4'h0;
         inst_reg <= 2'h0;
         sys_reg <= 1'b0;
      end else begin
         clksel_reg <= clksel_next;
         mainsrc_reg <= mainsrc_next;
         acc_reg <= acc_next;
         carry_reg <= carry_next;
         b_reg <= b_next;
         mem_reg <= mem_next;
         imm_reg <= imm_next;
         dptr_reg <= dptr_next;
         pc_reg <= pc_next;
         target_reg <= target_next;
         sp_reg <= sp_next;
         cmp_eq_reg <= cmp_eq_next;
         skip_reg <= skip_next;
         ctx_dp_reg <= ctx_dp_next;
         ctx_c_reg <= ctx_c_next;
         ctx_s_reg <= ctx_s_next;
         ctx_a_reg <= ctx_a_next;
         ctx_b_reg <= ctx_b_next;
         div_reg <= div_next;
         inst_reg <= inst_next;
         sys_reg <= sys_next;
      end
   end

   // Undefined-at-reset registers: software must load them first
   always_ff @(posedge pclk) begin
      e_reg <= e_next;
      d_reg <= d_next;
      if (stack_we) begin
         stack_mem[SP_W'(sp_reg + SP_ONE)] <= stack_wdata;
      end
   end
endmodule

// File: test/ccd_core_assertions.sv
// Port-level checker for the core bus and clock selector
`timescale 1ns/10ps
module ccd_core_assertions
   import ccd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic main_osc_enable,
   input wire logic machine_cycle
);
   logic acc;
   logic wr;
   logic [3:0] sel_reg, sel_next;
   logic c_reg, c_next, cv_reg, cv_next;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   // Shadow of selector and of carry; carry known only after reset or set/clear
   always_comb begin
      sel_next = sel_reg;
      c_next = c_reg;
      cv_next = cv_reg;
      if (wr && paddr == CCD_OFF_CLKSEL) sel_next = pwdata[3:0];
      if (wr && paddr == CCD_OFF_CMD) begin
         cv_next = pwdata[4:0] inside {CCD_OP_SET_C, CCD_OP_CLR_C};
         c_next = pwdata[4:0] == CCD_OP_SET_C;
      end
      if (wr && paddr == CCD_OFF_ACC) cv_next = 1'b0;
   end
   // Shadow registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_reg <= CCD_CLKSEL_RST;
         c_reg <= 1'b0;
         cv_reg <= 1'b1;
      end else begin
         sel_reg <= sel_next;
         c_reg <= c_next;
         cv_reg <= cv_next;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd(logic [11:0] a);
      acc && !pwrite && paddr == a;
   endsequence
   property p_ready; acc |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   property p_idle; !acc |-> prdata == 32'h0 && !pslverr; endproperty
   a_idle: assert property (p_idle) else $error("idle bus driven");
   property p_unmap; acc && paddr > CCD_OFF_DPTR |-> pslverr && prdata == 0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped access");
   property p_sel_rd; s_rd(CCD_OFF_CLKSEL) |-> prdata == {28'h0, sel_reg};
   endproperty
   a_sel_rd: assert property (p_sel_rd) else $error("selector read");
   property p_main_stop; main_osc_enable == !(sel_reg[0] && sel_reg[1]);
   endproperty
   a_main_stop: assert property (p_main_stop) else $error("main enable");
   property p_carry; s_rd(CCD_OFF_ACC) ##0 cv_reg |-> prdata[4] == c_reg;
   endproperty
   a_carry: assert property (p_carry) else $error("carry value");
   property p_sp_w; s_rd(CCD_OFF_STACK) |-> prdata[31:3] == 0; endproperty
   a_sp_w: assert property (p_sp_w) else $error("index width");
   property p_mc; machine_cycle |=> !machine_cycle; endproperty
   a_mc: assert property (p_mc) else $error("cycle pulse wide");
endmodule
////////////////////////////////////////////////////////////////////////
bind ccd_core ccd_core_assertions u_chk (.*);

// File: test/ccd_osc_model.sv
// Oscillator tick sources feeding the core
`timescale 1ns/10ps
module ccd_osc_model #(
   parameter int MAIN_P = 2,
   parameter int RING_P = 3,
   parameter int SUB_P = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic main_osc_enable,
   output logic main_osc_clk,
   output logic ring_osc_clk,
   output logic sub_osc_clk
);
   int cnt;
   // Free count; distinct periods tell the sources apart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt <= 0;
      else cnt <= cnt + 1;
   end
   // Stopped main oscillator gives no ticks at all
   assign main_osc_clk = main_osc_enable && cnt % MAIN_P == 0;
   assign ring_osc_clk = cnt % RING_P == 0;
   assign sub_osc_clk = cnt % SUB_P == 0;
endmodule

// File: test/tb_top.sv
// Self-checking bench for the core clock and datapath
`timescale 1ns/10ps
module tb_top;
   import ccd_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic skip_flag_in, main_osc_enable, system_clock, instruction_clock;
   logic machine_cycle, main_osc_clk, ring_osc_clk, sub_osc_clk;
   logic mc_t, last_err;
   logic [11:0] paddr;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] pwdata, prdata;
   logic [6:0] inpage_rom_addr;
   int fails, tests_run, i;
   ccd_core dut (.*);
   ccd_osc_model u_osc (.*);
   ////////////////////////////////////////////////////////////////////
   // Clock; toggle marks each instruction cycle
   initial begin
      pclk = 0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) if (machine_cycle === 1'b1) mc_t <= ~mc_t;
   task automatic give_verdict;
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer; waits for ready under a bound
   task automatic xfer(input logic [11:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         chk(0, 1);
         give_verdict;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                     input logic [31:0] msk = 32'hffff_ffff);
      logic [31:0] q;
      xfer(a, 1'b0, 32'h0, q);
      chk(q & msk, exp);
   endtask
   task automatic cmd(input ccd_op_t op);
      wr(CCD_OFF_CMD, 32'(op));
   endtask
   // Cycles between changes of clock or cycle marker; first two skipped
   task automatic gap(input logic m, input int exp);
      int n, k;
      logic s;
      for (k = 0; k < 3; k++) begin
         s = m ? mc_t : system_clock;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while ((m ? mc_t : system_clock) === s && n < 999);
      end
      chk(32'(n), 32'(exp));
      if (n >= 999) give_verdict;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {psel, penable, pwrite, skip_flag_in, mc_t} = '0;
      paddr = '0;
      pwdata = '0;
      fails = 0;
      tests_run = 0;
      presetn = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1;
      rd(CCD_OFF_CLKSEL, 32'hc);
      gap(0, 24);
      rd(CCD_OFF_STACK, 32'h7);
      rd(CCD_OFF_CMD, {30'h0, CCD_MAIN_RING});
      for (i = 0; i < 4; i++) begin
         wr(CCD_OFF_CLKSEL, 32'(i << 2));
         gap(0, 3 << i);
         wr(CCD_OFF_CLKSEL, 32'(i << 2 | 1));
         gap(0, 5 << i);
      end
      wr(CCD_OFF_CLKSEL, 32'h0);
      gap(1, 9);
      cmd(CCD_OP_CERAMIC);
      rd(CCD_OFF_CMD, {30'h0, CCD_MAIN_CER});
      gap(0, 2);
      wr(CCD_OFF_CLKSEL, 32'h3);
      // Let the write edge settle before looking at the pin
      @(negedge pclk);
      chk({31'h0, main_osc_enable}, 32'h0);
      cmd(CCD_OP_RCOSC);
      rd(CCD_OFF_CMD, {30'h0, CCD_MAIN_RC});
      // Carry behaviour across the add family
      wr(CCD_OFF_ACC, 32'he);
      wr(CCD_OFF_MEM, 32'h1);
      cmd(CCD_OP_SET_C);
      cmd(CCD_OP_ADC_MEM);
      rd(CCD_OFF_ACC, 32'h10);
      cmd(CCD_OP_ADD_MEM);
      rd(CCD_OFF_ACC, 32'h11);
      wr(CCD_OFF_STATUS, 32'h0000_0f00);
      cmd(CCD_OP_CLR_C);
      cmd(CCD_OP_ADD_IMM);
      rd(CCD_OFF_ACC, 32'h00);
      wr(CCD_OFF_ACC, 32'h5);
      cmd(CCD_OP_ROR_C);
      rd(CCD_OFF_ACC, 32'h12);
      wr(CCD_OFF_ACC, 32'hc);
      wr(CCD_OFF_MEM, 32'ha);
      cmd(CCD_OP_AND_MEM);
      rd(CCD_OFF_ACC, 32'h8, 32'hf);
      cmd(CCD_OP_OR_MEM);
      rd(CCD_OFF_ACC, 32'ha, 32'hf);
      cmd(CCD_OP_CMP_MEM);
      rd(CCD_OFF_STATUS, 32'h1, 32'h1);
      wr(CCD_OFF_STATUS, 32'h0000_0100);
      cmd(CCD_OP_CLRBIT);
      rd(CCD_OFF_MEM, 32'h8);
      wr(CCD_OFF_STATUS, 32'h0000_0000);
      cmd(CCD_OP_SETBIT);
      rd(CCD_OFF_MEM, 32'h9);
      // Register pair transfers and page address
      wr(CCD_OFF_ACC, 32'h9);
      wr(CCD_OFF_BREG, 32'h3);
      cmd(CCD_OP_BA_TO_E);
      rd(CCD_OFF_EREG, 32'h39);
      wr(CCD_OFF_EREG, 32'ha5);
      cmd(CCD_OP_E_TO_BA);
      rd(CCD_OFF_BREG, 32'ha);
      cmd(CCD_OP_A_TO_B);
      rd(CCD_OFF_BREG, 32'h5);
      wr(CCD_OFF_DREG, 32'h5);
      @(negedge pclk);
      chk({25'h0, inpage_rom_addr}, 32'h55);
      // Stack push, wrap and index copy
      wr(CCD_OFF_PC, 32'h40);
      cmd(CCD_OP_CALL);
      rd(CCD_OFF_STACK, 32'h0);
      cmd(CCD_OP_SP_TO_A);
      rd(CCD_OFF_ACC, 32'h0, 32'hf);
      cmd(CCD_OP_RET);
      rd(CCD_OFF_PC, 32'h0);
      for (i = 0; i < 9; i++) cmd(CCD_OP_CALL);
      rd(CCD_OFF_STACK, 32'h0);
      cmd(CCD_OP_TABLE);
      rd(CCD_OFF_STACK, 32'h1);
      // Context survives a nested call and table fetch
      wr(CCD_OFF_ACC, 32'h6);
      wr(CCD_OFF_BREG, 32'h2);
      wr(CCD_OFF_DPTR, 32'h1ab);
      cmd(CCD_OP_SET_C);
      skip_flag_in <= 1'b1;
      cmd(CCD_OP_INT);
      rd(CCD_OFF_STACK, 32'h2);
      wr(CCD_OFF_ACC, 32'h0);
      wr(CCD_OFF_BREG, 32'h0);
      wr(CCD_OFF_DPTR, 32'h0);
      skip_flag_in <= 1'b0;
      cmd(CCD_OP_CALL);
      cmd(CCD_OP_TABLE);
      cmd(CCD_OP_RETI);
      rd(CCD_OFF_ACC, 32'h16);
      rd(CCD_OFF_BREG, 32'h2);
      rd(CCD_OFF_DPTR, 32'h1ab);
      rd(CCD_OFF_STATUS, 32'h2, 32'h2);
      rd(12'h040, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      give_verdict;
   end
endmodule
